// File: logic/prbs_defs.svh
// Offsets, field positions, reset values and counts of the pattern unit
// Contract
// - Type bit picks PRBS15 or QRTS pattern
// - Switch off: transmit side sends pattern lineward
// - Switch on: receive side drives backplane pattern
// - Each insert rising edge flips one bit
// - Insert ignored while generator is off
// - Inserted error follows the switch direction
// - Switch off: invert tx output, rx input
// - Switch on: invert roles swap sides
// - Generator enable gates the pattern output
// - Read-only lock flag shows checker lock
`ifndef PRBS_DEFS_SVH
`define PRBS_DEFS_SVH

// Register offsets
`define OFS_CSR 3'h0
`define OFS_SWITCH 3'h1
`define OFS_IRQ_STAT 3'h2
`define OFS_IRQ_MASK 3'h3
`define OFS_ERR_CNT 3'h4

// Control and status field positions
`define BIT_TYPE 7
`define BIT_ERR_INS 6
`define BIT_INVERT 5
`define BIT_LOCK 4
`define BIT_CHK_EN 3
`define BIT_GEN_EN 2
`define BIT_SWITCH 3

// Interrupt status positions
`define IRQ_LOCK_GAIN 0
`define IRQ_LOCK_LOSS 1
`define IRQ_BIT_ERR 2
`define IRQ_ERR_SENT 3

// Reset values and write masks
`define CSR_RESET 8'h00
`define CSR_WMASK 8'hef
`define SWITCH_RESET 8'h00
`define SWITCH_WMASK 8'h08
`define IRQ_RESET 4'h0
`define LFSR_SEED 20'h00001

// Checker counts
`define LOCK_LAST 6'h1f
`define LOSS_LAST 4'h7
`define WINDOW_LAST 6'h3f

`endif

// File: logic/prbs_pkg.sv
// Types and pattern functions of the test pattern unit
package prbs_pkg;

  // Pattern shift register, wide enough for the quasi-random pattern
  typedef logic [19:0] lfsr_t;

  // Checker states
  typedef enum logic [2:0] {
    CHK_IDLE = 3'h1,
    CHK_HUNT = 3'h2,
    CHK_LOCKED = 3'h4
  } chk_state_t;

  // Feedback bit: x^15+x^14+1 or x^20+x^17+1
  function automatic logic pattern_fb(lfsr_t r, logic qrts);
    pattern_fb = qrts ? (r[19] ^ r[16]) : (r[14] ^ r[13]);
  endfunction : pattern_fb

  // Sent bit: quasi-random forces a one after thirteen zeros
  function automatic logic pattern_bit(lfsr_t r, logic qrts);
    logic fb;
    fb = pattern_fb(r, qrts);
    pattern_bit = fb | (qrts & (r[12:0] == 13'h0000));
  endfunction : pattern_bit

endpackage : prbs_pkg

// File: logic/pattern_lane_if.sv
// Bit lane between the pattern unit and its generator or checker
`timescale 1ns/1ps
interface pattern_lane_if;
  logic strobe;
  logic qrts;
  logic enable;
  logic data;
  modport producer(input strobe, input qrts, input enable, output data);
  modport consumer(input strobe, input qrts, input enable, input data);
endinterface : pattern_lane_if

// File: logic/pattern_generator.sv
// Pseudo-random and quasi-random pattern generator
`timescale 1ns/1ps
`include "prbs_defs.svh"
module pattern_generator (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pattern lane
  pattern_lane_if.producer lane
);
  import prbs_pkg::*;

  lfsr_t shiftReg;
  lfsr_t next_shiftReg;

  // Advance by one bit; an all-zero register reseeds
  assign next_shiftReg = (shiftReg == 20'h00000) ? `LFSR_SEED :
    {shiftReg[18:0], pattern_fb(shiftReg, lane.qrts)};
  assign lane.data = pattern_bit(shiftReg, lane.qrts);

  // One step per payload bit while enabled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shiftReg <= `LFSR_SEED;
    end else if (lane.strobe && lane.enable) begin
      shiftReg <= next_shiftReg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  prbs_taps_a: assert property (
    @(posedge core_clk) disable iff (rst)
    lane.strobe && lane.enable && !lane.qrts && shiftReg != 20'h00000
    |=> shiftReg[0] == $past(shiftReg[14] ^ shiftReg[13]))
    else $error("PRBS15 feedback taps wrong");
  qrts_taps_a: assert property (
    @(posedge core_clk) disable iff (rst)
    lane.strobe && lane.enable && lane.qrts && shiftReg != 20'h00000
    |=> shiftReg[0] == $past(shiftReg[19] ^ shiftReg[16]))
    else $error("QRTS feedback taps wrong");
  gen_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !lane.strobe |=> $stable(shiftReg))
    else $error("Generator moved without a bit strobe");
endmodule : pattern_generator

// File: logic/pattern_checker.sv
// Self-synchronising pattern checker with lock detection
`timescale 1ns/1ps
`include "prbs_defs.svh"
module pattern_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pattern lane
  pattern_lane_if.consumer lane,
  // Status
  output logic locked,
  output logic bitError,
  output prbs_pkg::chk_state_t state
);
  import prbs_pkg::*;

  lfsr_t refReg;
  lfsr_t next_refReg;
  chk_state_t next_state;
  logic mismatch;
  logic [5:0] matchCnt;
  logic [5:0] next_matchCnt;
  logic [5:0] winCnt;
  logic [5:0] next_winCnt;
  logic [3:0] errCnt;
  logic [3:0] next_errCnt;
  logic goodMatch;

  // Compare, then reload from input while hunting, flywheel when locked
  assign mismatch = lane.data != pattern_bit(refReg, lane.qrts);
  assign goodMatch = !mismatch && refReg != 20'h00000;
  assign next_refReg = (state == CHK_LOCKED) ?
    {refReg[18:0], pattern_fb(refReg, lane.qrts)} :
    {refReg[18:0], lane.data};
  assign locked = state == CHK_LOCKED;

  // Count matches while hunting, errors per window while locked
  assign next_matchCnt = (state != CHK_HUNT) ? 6'h00 :
    !lane.strobe ? matchCnt :
    goodMatch ? 6'(matchCnt + 6'h01) : 6'h00;
  assign next_winCnt = (state != CHK_LOCKED) ? 6'h00 :
    lane.strobe ? 6'(winCnt + 6'h01) : winCnt;
  assign next_errCnt = (state != CHK_LOCKED) ? 4'h0 :
    !lane.strobe ? errCnt :
    (winCnt == `WINDOW_LAST) ? {3'h0, mismatch} :
    mismatch ? 4'(errCnt + 4'h1) : errCnt;

  // Lock state machine
  always_comb begin
    next_state = state;
    case (state)
      CHK_IDLE: begin
        if (lane.enable) next_state = CHK_HUNT;
      end
      CHK_HUNT: begin
        if (!lane.enable) next_state = CHK_IDLE;
        else if (lane.strobe && goodMatch && matchCnt == `LOCK_LAST)
          next_state = CHK_LOCKED;
      end
      CHK_LOCKED: begin
        if (!lane.enable) next_state = CHK_IDLE;
        else if (lane.strobe && mismatch && errCnt == `LOSS_LAST)
          next_state = CHK_HUNT;
      end
      default: next_state = CHK_IDLE;
    endcase
  end

  // State and counters
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= CHK_IDLE;
      refReg <= `LFSR_SEED;
      matchCnt <= 6'h00;
      winCnt <= 6'h00;
      errCnt <= 4'h0;
      bitError <= 1'h0;
    end else begin
      state <= next_state;
      if (lane.strobe) refReg <= next_refReg;
      matchCnt <= next_matchCnt;
      winCnt <= next_winCnt;
      errCnt <= next_errCnt;
      bitError <= lane.strobe && locked && mismatch;
    end
  end

  ////////////////////////////////////////////////////////////////////
  resync_load_a: assert property (
    @(posedge core_clk) disable iff (rst)
    state == CHK_HUNT && lane.strobe |=> refReg[0] == $past(lane.data))
    else $error("Checker did not reload from incoming bit");
  lock_drop_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !lane.enable |=> !locked)
    else $error("Lock held with checker disabled");
endmodule : pattern_checker

// File: logic/prbs_qrts_test_pattern_unit.sv
// Per-channel PRBS/QRTS test pattern unit with register port
`timescale 1ns/1ps
`include "prbs_defs.svh"
module prbs_qrts_test_pattern_unit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Transmit framer side
  input wire logic txBitStrobe,
  input wire logic txPayload,
  output logic txLine,
  // Receive framer side
  input wire logic rxBitStrobe,
  input wire logic rxLine,
  output logic rxBackplane,
  // Interrupt and status
  output logic irq,
  output prbs_pkg::chk_state_t checkerState
);
  import prbs_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Register decode helper
  function automatic logic addr_hit(logic [2:0] a, logic [2:0] ofs);
    addr_hit = a == ofs;
  endfunction : addr_hit

  // Registers
  logic [7:0] csr;
  logic [7:0] switchReg;
  logic [3:0] irqStatus;
  logic [3:0] irqMask;
  logic [7:0] errCount;
  logic errPending;
  logic lockedDly;

  // Next values
  logic [7:0] next_csr;
  logic [3:0] next_irqStatus;
  logic [7:0] next_errCount;
  logic next_errPending;
  logic next_txLine;
  logic next_rxBackplane;
  logic [7:0] next_regRdData;

  // Decoded strobes
  wire wrCsr = regWrite && addr_hit(regAddr, `OFS_CSR);
  wire wrSwitch = regWrite && addr_hit(regAddr, `OFS_SWITCH);
  wire wrIrqStat = regWrite && addr_hit(regAddr, `OFS_IRQ_STAT);
  wire wrIrqMask = regWrite && addr_hit(regAddr, `OFS_IRQ_MASK);
  wire rdErrCnt = regRead && addr_hit(regAddr, `OFS_ERR_CNT);

  // Control fields
  wire patternTypeSelect = csr[`BIT_TYPE];
  wire singleErrorInsert = csr[`BIT_ERR_INS];
  wire patternDataInvert = csr[`BIT_INVERT];
  wire patternCheckerEnable = csr[`BIT_CHK_EN];
  wire patternGeneratorEnable = csr[`BIT_GEN_EN];
  wire patternSwitch = switchReg[`BIT_SWITCH];

  // Checker results
  logic patternLockFlag;
  logic chkBitError;

  ////////////////////////////////////////////////////////////////////
  // Direction steering: switch moves generator to receive side
  wire genStrobe = patternSwitch ? rxBitStrobe : txBitStrobe;
  wire chkStrobe = patternSwitch ? txBitStrobe : rxBitStrobe;
  wire chkRaw = patternSwitch ? txPayload : rxLine;
  wire genActive = patternGeneratorEnable && genStrobe;

  pattern_lane_if genLane();
  pattern_lane_if chkLane();

  // Lane drive toward generator and checker
  assign genLane.strobe = genStrobe;
  assign genLane.qrts = patternTypeSelect;
  assign genLane.enable = patternGeneratorEnable;
  assign chkLane.strobe = chkStrobe;
  assign chkLane.qrts = patternTypeSelect;
  assign chkLane.enable = patternCheckerEnable;
  assign chkLane.data = chkRaw ^ patternDataInvert;

  pattern_generator u_gen (
    .core_clk(core_clk),
    .rst(rst),
    .lane(genLane.producer)
  );

  pattern_checker u_chk (
    .core_clk(core_clk),
    .rst(rst),
    .lane(chkLane.consumer),
    .locked(patternLockFlag),
    .bitError(chkBitError),
    .state(checkerState)
  );

  ////////////////////////////////////////////////////////////////////
  // Error insertion on a written 0-to-1 of the insert bit
  wire insertRise = wrCsr && regWrData[`BIT_ERR_INS] &&
    !singleErrorInsert;
  assign next_errPending = patternGeneratorEnable &&
    (insertRise || (errPending && !genStrobe));
  wire errSent = genActive && errPending;

  // Outgoing pattern bit after inversion and insertion
  wire genBit = genLane.data ^ patternDataInvert ^ errPending;

  // Output selection per direction
  assign next_txLine = (patternGeneratorEnable && !patternSwitch) ?
    genBit : txPayload;
  assign next_rxBackplane = (patternGeneratorEnable && patternSwitch) ?
    genBit : rxLine;

  ////////////////////////////////////////////////////////////////////
  // Events and interrupt status
  wire lockGain = patternLockFlag && !lockedDly;
  wire lockLoss = !patternLockFlag && lockedDly;
  wire [3:0] irqEvents = {errSent, chkBitError, lockLoss, lockGain};
  wire [3:0] irqClear = wrIrqStat ? regWrData[3:0] : 4'h0;
  // Set wins over a same-cycle clear
  assign next_irqStatus = (irqStatus & ~irqClear) | irqEvents;
  assign irq = |(irqStatus & irqMask);

  // Saturating bit-error count, cleared by reading it
  wire [7:0] errBase = rdErrCnt ? 8'h00 : errCount;
  assign next_errCount = (chkBitError && errBase != 8'hff) ?
    8'(errBase + 8'h01) : errBase;

  // Control register write; lock bit is read-only
  assign next_csr = wrCsr ?
    ((regWrData & `CSR_WMASK) | (csr & ~`CSR_WMASK)) : csr;

  ////////////////////////////////////////////////////////////////////
  // Read data mux
  always_comb begin
    next_regRdData = 8'h00;
    case (regAddr)
      `OFS_CSR: begin
        next_regRdData = csr;
        next_regRdData[`BIT_LOCK] = patternLockFlag;
      end
      `OFS_SWITCH: next_regRdData = switchReg;
      `OFS_IRQ_STAT: next_regRdData = {4'h0, irqStatus};
      `OFS_IRQ_MASK: next_regRdData = {4'h0, irqMask};
      `OFS_ERR_CNT: next_regRdData = errCount;
      default: next_regRdData = 8'h00;
    endcase
  end

  // Register file
  always_ff @(posedge core_clk) begin
    if (rst) begin
      csr <= `CSR_RESET;
      switchReg <= `SWITCH_RESET;
      irqStatus <= `IRQ_RESET;
      irqMask <= `IRQ_RESET;
      errCount <= 8'h00;
      regRdData <= 8'h00;
    end else begin
      csr <= next_csr;
      if (wrSwitch) switchReg <= regWrData & `SWITCH_WMASK;
      irqStatus <= next_irqStatus;
      if (wrIrqMask) irqMask <= regWrData[3:0];
      errCount <= next_errCount;
      regRdData <= regRead ? next_regRdData : 8'h00;
    end
  end

  // Insertion and lock tracking
  always_ff @(posedge core_clk) begin
    if (rst) begin
      errPending <= 1'h0;
      lockedDly <= 1'h0;
    end else begin
      errPending <= next_errPending;
      lockedDly <= patternLockFlag;
    end
  end

  // Transmit line output, one bit per transmit strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      txLine <= 1'h0;
    end else if (txBitStrobe) begin
      txLine <= next_txLine;
    end
  end

  // Receive backplane output, one bit per receive strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxBackplane <= 1'h0;
    end else if (rxBitStrobe) begin
      rxBackplane <= next_rxBackplane;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  line_gen_a: assert property (
    txBitStrobe && patternGeneratorEnable && !patternSwitch &&
    !errPending
    |=> txLine == $past(genLane.data ^ patternDataInvert))
    else $error("Line did not carry the generated pattern");

  backplane_gen_a: assert property (
    rxBitStrobe && patternGeneratorEnable && patternSwitch &&
    !errPending
    |=> rxBackplane == $past(genLane.data ^ patternDataInvert))
    else $error("Backplane did not carry the generated pattern");

  err_single_a: assert property (
    errPending && genStrobe && !insertRise |=> !errPending)
    else $error("Inserted error not consumed after one bit");

  err_hold_a: assert property (
    wrCsr && regWrData[`BIT_ERR_INS] && singleErrorInsert &&
    !errPending |=> !errPending)
    else $error("Held insert bit caused another error");

  err_arm_a: assert property (
    insertRise && patternGeneratorEnable |=> errPending)
    else $error("Insert edge did not arm an error");

  err_off_a: assert property (
    !patternGeneratorEnable |=> !errPending)
    else $error("Error armed while generator is off");

  err_tx_a: assert property (
    errPending && txBitStrobe && patternGeneratorEnable &&
    !patternSwitch
    |=> txLine != $past(genLane.data ^ patternDataInvert))
    else $error("Error not applied toward the line");

  err_rx_a: assert property (
    errPending && rxBitStrobe && patternGeneratorEnable &&
    patternSwitch
    |=> rxBackplane != $past(genLane.data ^ patternDataInvert))
    else $error("Error not applied toward the backplane");

  inv_rx_chk_a: assert property (
    !patternSwitch && rxBitStrobe
    |-> chkLane.strobe && chkLane.data == (rxLine ^ patternDataInvert))
    else $error("Receive check input not inverted as set");

  inv_tx_chk_a: assert property (
    patternSwitch && txBitStrobe
    |-> chkLane.strobe && chkLane.data == (txPayload ^ patternDataInvert))
    else $error("Transmit check input not inverted as set");

  gen_off_a: assert property (
    txBitStrobe && (!patternGeneratorEnable || patternSwitch)
    |=> txLine == $past(txPayload))
    else $error("Line not passing payload with generator idle");

  lock_read_a: assert property (
    regRead && addr_hit(regAddr, `OFS_CSR)
    |=> regRdData[`BIT_LOCK] == $past(patternLockFlag))
    else $error("Lock flag read back wrong");

  irq_level_a: assert property (
    lockGain && irqMask[`IRQ_LOCK_GAIN] |=> irq [*2])
    else $error("Lock interrupt not raised and held");

endmodule : prbs_qrts_test_pattern_unit

// File: test/far_side_model.sv
// Line and backplane far side: bit strobes and reference pattern source
`timescale 1ns/1ps
module far_side_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pattern control
  input wire logic sendPattern,
  input wire logic toTx,
  input wire logic invertOut,
  input wire logic randBit,
  input wire logic loopBack,
  input wire logic loopIn,
  // Framer bit lanes
  output logic txBitStrobe,
  output logic rxBitStrobe,
  output logic txPayload,
  output logic rxLine
);
  logic [14:0] refReg;
  logic [1:0] phase;
  logic nextBit;

  // Reference bit of the x^15+x^14+1 sequence, optionally inverted
  assign nextBit = refReg[14] ^ refReg[13] ^ invertOut;

  // One bit every three cycles; data changes with its strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase <= 2'h0;
      refReg <= 15'h0001;
      txBitStrobe <= 1'b0;
      rxBitStrobe <= 1'b0;
      txPayload <= 1'b0;
      rxLine <= 1'b0;
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      txBitStrobe <= (phase == 2'h0);
      rxBitStrobe <= (phase == 2'h0);
      if (phase == 2'h0) begin
        refReg <= {refReg[13:0], refReg[14] ^ refReg[13]};
        // Loop returns the receive backplane bit as transmit payload
        txPayload <= loopBack ? loopIn :
          ((sendPattern & toTx) ? nextBit : randBit);
        rxLine <= (sendPattern & ~toTx) ? nextBit : randBit;
      end
    end
  end
endmodule : far_side_model

// File: test/tb.sv
// Self-checking bench of the test pattern unit
`timescale 1ns/1ps
module tb;
  import prbs_pkg::*;
  logic core_clk, rst, regWrite, regRead, txLine, rxBackplane, irq;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, rdv;
  logic txBitStrobe, rxBitStrobe, txPayload, rxLine;
  logic sendPattern, toTx, invertOut, randBit, loopBack;
  chk_state_t checkerState;
  logic [31:0] seed;
  logic watchOn, watchRx, inv, strobeD, bitNow;
  logic [15:0] hist;
  int nBits, nViol, n_fail, samples_checked;

  prbs_qrts_test_pattern_unit u_prbs_qrts_test_pattern_unit (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .txBitStrobe(txBitStrobe),
    .txPayload(txPayload), .txLine(txLine), .rxBitStrobe(rxBitStrobe),
    .rxLine(rxLine), .rxBackplane(rxBackplane), .irq(irq),
    .checkerState(checkerState));
  far_side_model u_far_side_model (
    .core_clk(core_clk), .rst(rst), .sendPattern(sendPattern),
    .toTx(toTx), .invertOut(invertOut), .randBit(randBit),
    .loopBack(loopBack), .loopIn(rxBackplane),
    .txBitStrobe(txBitStrobe), .rxBitStrobe(rxBitStrobe),
    .txPayload(txPayload), .rxLine(rxLine));

  ////////////////////////////////////////////////////////////////////////
  // Random source
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    lfsr_next = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr_next

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Random bits into the far side every cycle
  always @(posedge core_clk) begin
    seed <= lfsr_next(seed);
    randBit <= seed[0];
  end

  // Output monitor: counts breaks of s[n]=s[n-14]^s[n-15]^inv
  always @(posedge core_clk) begin
    strobeD <= watchRx ? rxBitStrobe : txBitStrobe;
    bitNow = watchRx ? rxBackplane : txLine;
    if (!watchOn) begin
      nBits <= 0;
      nViol <= 0;
    end else if (strobeD) begin
      if (nBits >= 15 && bitNow !== (hist[13] ^ hist[14] ^ inv))
        nViol <= nViol + 1;
      hist <= {hist[14:0], bitNow};
      nBits <= nBits + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(posedge core_clk);
    d = regRdData;
  endtask : rd

  task automatic bits(int n);
    repeat (n * 3) @(posedge core_clk);
  endtask : bits

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    #(40 * 30000);
    n_fail++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1; regAddr = 3'h0; regWrData = 8'h00; regWrite = 1'b0;
    regRead = 1'b0; sendPattern = 1'b0; toTx = 1'b0; invertOut = 1'b0;
    loopBack = 1'b0;
    seed = 32'h610d; randBit = 1'b0; watchOn = 1'b0; watchRx = 1'b0;
    inv = 1'b0; strobeD = 1'b0; hist = 16'h0000;
    n_fail = 0; samples_checked = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    // Reset values, unmapped index, read-only lock bit
    for (int a = 0; a < 6; a++) begin
      rd(a[2:0], rdv);
      check("reset reg", 8'h00, rdv);
    end
    wr(3'h5, 8'hff);
    rd(3'h5, rdv);
    check("unmapped", 8'h00, rdv);
    wr(3'h0, 8'h33);
    rd(3'h0, rdv);
    check("csr rw", 8'h23, rdv);
    $display("test registers done");
    // Generator in both directions, plain and inverted, with one error
    for (int k = 0; k < 4; k++) begin
      wr(3'h1, k[1] ? 8'h08 : 8'h00);
      wr(3'h0, {2'b00, k[0], 5'h04});
      watchRx <= k[1];
      inv <= k[0];
      bits(20);
      watchOn <= 1'b1;
      bits(60);
      check("clean pattern", 8'h00, nViol[7:0]);
      wr(3'h0, {2'b01, k[0], 5'h04});
      bits(40);
      wr(3'h0, {2'b01, k[0], 5'h04});
      bits(40);
      check("one error", 8'h03, nViol[7:0]);
      watchOn <= 1'b0;
      wr(3'h0, 8'h00);
    end
    $display("test generator done");
    // Generator off: payload passes, insert request has no effect
    inv <= 1'b0;
    wr(3'h1, 8'h00);
    watchRx <= 1'b0;
    wr(3'h0, 8'h40);
    watchOn <= 1'b1;
    bits(60);
    check("gen off", 8'h01, {7'h00, nViol != 0});
    watchOn <= 1'b0;
    wr(3'h0, 8'h44);
    bits(20);
    watchOn <= 1'b1;
    bits(60);
    check("no error", 8'h00, nViol[7:0]);
    watchOn <= 1'b0;
    // Quasi-random pattern does not obey the PRBS15 recurrence
    wr(3'h0, 8'h84);
    bits(20);
    watchOn <= 1'b1;
    bits(60);
    check("qrts", 8'h01, {7'h00, nViol != 0});
    watchOn <= 1'b0;
    wr(3'h0, 8'h00);
    $display("test pattern type done");
    // Checker lock per direction and invert, lock interrupt
    wr(3'h3, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(3'h1, k[1] ? 8'h08 : 8'h00);
      toTx <= k[1];
      invertOut <= k[0];
      sendPattern <= 1'b1;
      wr(3'h0, {2'b00, k[0], 5'h08});
      bits(60);
      rd(3'h0, rdv);
      check("lock", {2'b00, k[0], 5'h18}, rdv);
      check("state", {5'h00, CHK_LOCKED}, {5'h00, checkerState});
      check("irq on", 8'h01, {7'h00, irq});
      wr(3'h2, 8'h01);
      @(posedge core_clk);
      check("irq clr", 8'h00, {7'h00, irq});
      sendPattern <= 1'b0;
      bits(100);
      rd(3'h0, rdv);
      check("lost", {2'b00, k[0], 5'h08}, rdv);
      // Loss and bit-error events, 8 to 15 errors before the loss
      rd(3'h2, rdv);
      check("irq stat", 8'h06, rdv & 8'h06);
      rd(3'h4, rdv);
      check("err count", 8'h08, rdv & 8'hf8);
      wr(3'h0, 8'h00);
      wr(3'h2, 8'h0f);
    end
    $display("test checker done");
    // Loopback: quasi-random pattern out to backplane, checked on return
    wr(3'h1, 8'h08);
    loopBack <= 1'b1;
    wr(3'h0, 8'h8c);
    bits(80);
    rd(3'h4, rdv);
    wr(3'h0, 8'hcc);
    bits(20);
    rd(3'h0, rdv);
    check("qrts lock", 8'hdc, rdv);
    rd(3'h4, rdv);
    check("err seen", 8'h01, rdv);
    wr(3'h0, 8'h00);
    loopBack <= 1'b0;
    $display("test loopback done");
    print_verdict();
  end
endmodule : tb
